// [sensor_config_register_bank.sv]
// Purpose: Configuration register bank of a monochrome image sensor.
// Assumes: A serial bus engine delivers decoded byte writes and read requests
//          with an 8-bit register address on sys_clk_i.
// Notes:   Outputs are registered; read data appears one cycle after rd_en_i.
//
// Functional notes
// R01 - Bank enable switches offset bank on only with offset DAC enable also set.
// R02 - Bank enable gates access to the bias power setting register.
// R03 - Revision bits 4:0 return the silicon revision and ignore writes.
// R04 - Main configuration bit 6 selects serial port when set, parallel when clear.
// R05 - Serial port selected puts the six upper data outputs in high impedance.
// R06 - Main configuration bit 5 powers down the whole sensor.
// R07 - Main configuration bit 4 powers down the video gain amplifier.
// R08 - Main configuration bit 3 routes pixel core straight to the converter.
// R09 - Writing one to bit 2 triggers system reset; logic clears it automatically.
// R10 - Main configuration bit 1 puts whole video port in high impedance.
// R11 - Main configuration bit 0 set selects snapshot, clear selects video mode.
// R12 - Gain register bits 4:0 hold the overall video gain code.
// R13 - Gain bit 6 is offset DAC enable, needed with bank enable.
// R14 - Integration count: low byte at offset 3, upper bits from offset 5 bits 2:0.
// R15 - Idle count: low byte at offset 4, upper bits from offset 5 bits 5:3.
// R16 - Host must not program idle low byte to zero.
// R17 - Bias trim bits 7:4: 0000 nominal, 1111 plus, 1110 minus 6.7 mA.
// R18 - Host should program bias trim once after each system reset.
// R19 - Host sets bank enable before writing the bias power register.
// R20 - Offset bit 7 gives polarity: one positive, zero negative.
// R21 - Offset bits 5:0 hold the offset magnitude.
// R22 - Host sets both enables before relying on the offset register.
// R23 - Write: address with write bit, register address, data; each byte acknowledged.
// R24 - Read: address phase, repeated start, read; host ends with not-acknowledge.
// R25 - Bias register writes ignored while bank enable clear; reserved bits read zero.
`include "sensor_cfg_consts.svh"

module sensor_config_register_bank
  import sensor_cfg_pkg::*;
#(
  parameter logic [4:0] SILICON_REVISION = 5'h01  // Arbitrary value.
)(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] rd_data_o,
  output logic            rd_valid_o,
  output logic            serial_port_select_o,
  output logic [5:0]      upper_data_oe_n_o,
  output logic            video_port_high_z_o,
  output logic            sensor_power_down_o,
  output logic            amplifier_power_down_o,
  output logic            amplifier_route_around_o,
  output logic            system_reset_o,
  output logic            snapshot_mode_o,
  output logic [4:0]      gain_code_o,
  output logic            offset_bank_active_o,
  output logic [10:0]     integration_count_o,
  output logic [10:0]     idle_count_o,
  output logic [3:0]      bias_current_trim_o,
  output logic            offset_polarity_o,
  output logic [5:0]      offset_magnitude_o
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic             offset_bank_enable_r;
  logic [7:0]       main_configuration_r;
  logic [7:0]       video_gain_control_r;
  logic [7:0]       integration_time_low_r;
  logic [7:0]       idle_time_low_r;
  logic [7:0]       time_high_bits_r;
  logic [7:0]       bias_power_setting_r;
  logic [7:0]       offset_adjustment_r;
  soft_rst_state_t  soft_state_r;
  soft_rst_state_t  soft_state_nxt;
  logic [3:0]       soft_cnt_r;
  logic             soft_reset_w;
  logic             reset_all_w;
  logic [7:0]       rd_mux_w;

  // Decoded write strobes per register.
  logic wr_rev_w;
  logic wr_main_configuration_w;
  logic wr_gain_w;
  logic wr_itl_w;
  logic wr_idl_w;
  logic wr_timeh_w;
  logic wr_bias_w;
  logic wr_offs_w;

  // Address decode; the bias register only accepts writes while the bank is enabled.
  assign wr_rev_w   = wr_en_i && (reg_addr_i == `OFS_REV); // R23
  assign wr_main_configuration_w  = wr_en_i && (reg_addr_i == `OFS_MAIN_CONFIGURATION_REG);
  assign wr_gain_w  = wr_en_i && (reg_addr_i == `OFS_GAIN);
  assign wr_itl_w   = wr_en_i && (reg_addr_i == `OFS_ITL);
  assign wr_idl_w   = wr_en_i && (reg_addr_i == `OFS_IDL);
  assign wr_timeh_w = wr_en_i && (reg_addr_i == `OFS_TIMEH);
  assign wr_bias_w  = wr_en_i && (reg_addr_i == `OFS_BIAS) && offset_bank_enable_r; // R02 R25
  assign wr_offs_w  = wr_en_i && (reg_addr_i == `OFS_OFFS);

  // A soft reset restores every register except the main configuration bits themselves.
  assign soft_reset_w = (soft_state_r == soft_active);
  assign reset_all_w  = rst_i || soft_reset_w;

  // ****************************************************************
  // Soft reset sequencer
  // ****************************************************************
  // Writing one to the reset bit starts a fixed-length system reset, then the bit clears.
  always_comb
  begin
    soft_state_nxt = soft_state_r;
    case (soft_state_r)
      soft_idle:
      begin
        if (wr_main_configuration_w && wr_data_i[`BIT_SOFT_RST])
          soft_state_nxt = soft_active; // R09
      end
      soft_active:
      begin
        if (soft_cnt_r == `SOFT_RST_CYCLES - 4'h1)
          soft_state_nxt = soft_done;
      end
      soft_done:
      begin
        // A new request in the closing cycle starts another sequence at once.
        if (wr_main_configuration_w && wr_data_i[`BIT_SOFT_RST])
          soft_state_nxt = soft_active; // R09
        else
          soft_state_nxt = soft_idle;
      end
      default:
        soft_state_nxt = soft_idle;
    endcase
  end

  // State register of the sequencer.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      soft_state_r <= soft_idle;
    else
      soft_state_r <= soft_state_nxt;
  end

  // Counts cycles of the active soft reset.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !soft_reset_w)
      soft_cnt_r <= 4'h0;
    else
      soft_cnt_r <= soft_cnt_r + 4'h1;
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Bank enable; revision bits are constant and never written.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_all_w)
      offset_bank_enable_r <= 1'b0;
    else if (wr_rev_w)
      offset_bank_enable_r <= wr_data_i[`BIT_BANK_EN]; // R03
  end

  // Main configuration; the reset bit clears itself once the sequence ends.
  // A host write in that closing cycle wins over the clear, so no request is lost.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      main_configuration_r <= `RST_MAIN_CONFIGURATION;
    else if (wr_main_configuration_w && !soft_reset_w)
      main_configuration_r <= wr_data_i & `MSK_MAIN_CONFIGURATION;
    else if (soft_state_r == soft_done)
      main_configuration_r[`BIT_SOFT_RST] <= 1'b0; // R09
  end

  // Gain, integration, idle, high bits and offset registers.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_all_w)
    begin
      video_gain_control_r   <= `RST_GAIN;
      integration_time_low_r <= `RST_ITL;
      idle_time_low_r        <= `RST_IDL;
      time_high_bits_r       <= `RST_TIMEH;
      offset_adjustment_r    <= `RST_OFFS;
    end
    else
    begin
      if (wr_gain_w)
        video_gain_control_r <= wr_data_i & `MSK_GAIN; // R12 R13
      if (wr_itl_w)
        integration_time_low_r <= wr_data_i; // R14
      if (wr_idl_w)
        idle_time_low_r <= wr_data_i; // R15
      if (wr_timeh_w)
        time_high_bits_r <= wr_data_i & `MSK_TIMEH;
      if (wr_offs_w)
        offset_adjustment_r <= wr_data_i & `MSK_OFFS; // R20 R21
    end
  end

  // Bias trim register, reachable only while the bank is enabled.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_all_w)
      bias_power_setting_r <= `RST_BIAS;
    else if (wr_bias_w)
      bias_power_setting_r <= wr_data_i & `MSK_BIAS; // R17 R25
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Read multiplexer; unmapped addresses and reserved bits read zero.
  always_comb
  begin
    case (reg_addr_i)
      `OFS_REV:      rd_mux_w = {offset_bank_enable_r, 2'h0, SILICON_REVISION}; // R03
      `OFS_MAIN_CONFIGURATION_REG: rd_mux_w = main_configuration_r;
      `OFS_GAIN:     rd_mux_w = video_gain_control_r;
      `OFS_ITL:      rd_mux_w = integration_time_low_r;
      `OFS_IDL:      rd_mux_w = idle_time_low_r;
      `OFS_TIMEH:    rd_mux_w = time_high_bits_r;
      `OFS_BIAS:     rd_mux_w = offset_bank_enable_r ? bias_power_setting_r : 8'h00; // R02
      `OFS_OFFS:     rd_mux_w = offset_adjustment_r;
      default:       rd_mux_w = 8'h00; // R25
    endcase
  end

  // Registered read answer, one cycle after the request.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= rd_en_i; // R24
      if (rd_en_i)
        rd_data_o <= rd_mux_w;
    end
  end

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  // Port mode and tri-state controls of the digital video port.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      serial_port_select_o <= 1'b0;
      upper_data_oe_n_o    <= 6'h00;
      video_port_high_z_o  <= 1'b0;
    end
    else
    begin
      serial_port_select_o <= main_configuration_r[`BIT_SERIAL]; // R04
      // Upper data lines float in serial mode or when the whole port floats.
      upper_data_oe_n_o    <= {6{main_configuration_r[`BIT_SERIAL]
                                | main_configuration_r[`BIT_HIGH_Z]}}; // R05
      video_port_high_z_o  <= main_configuration_r[`BIT_HIGH_Z]; // R10
    end
  end

  // Power, amplifier routing and operating mode controls.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sensor_power_down_o      <= 1'b0;
      amplifier_power_down_o   <= 1'b0;
      amplifier_route_around_o <= 1'b0;
      snapshot_mode_o          <= 1'b1;
    end
    else
    begin
      sensor_power_down_o      <= main_configuration_r[`BIT_PWR_DOWN]; // R06
      amplifier_power_down_o   <= main_configuration_r[`BIT_AMP_PD]; // R07
      amplifier_route_around_o <= main_configuration_r[`BIT_ROUTE]; // R08
      snapshot_mode_o          <= main_configuration_r[`BIT_SNAPSHOT]; // R11
    end
  end

  // System reset pulse, high for the whole active phase of the sequencer.
  // It lags the sequencer by one cycle, so downstream timing logic sees a clean level.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      system_reset_o <= 1'b0;
    else
      system_reset_o <= soft_reset_w; // R09
  end

  // Gain code and the combined offset bank switch.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      gain_code_o          <= 5'h00;
      offset_bank_active_o <= 1'b0;
    end
    else
    begin
      gain_code_o          <= video_gain_control_r[4:0]; // R12
      // Either enable alone leaves the offset bank off.
      offset_bank_active_o <= offset_bank_enable_r
                              & video_gain_control_r[`BIT_DAC_EN]; // R01 R13
    end
  end

  // Integration and idle counts, each an 11-bit value spread over two registers.
  // A host that updates low and high bytes in separate writes briefly shows a mixed count.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      integration_count_o <= 11'h000;
      idle_count_o        <= 11'h000;
    end
    else
    begin
      integration_count_o <= {time_high_bits_r[2:0], integration_time_low_r}; // R14
      idle_count_o        <= {time_high_bits_r[5:3], idle_time_low_r}; // R15
    end
  end

  // Bias trim and signed offset fields.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      bias_current_trim_o <= 4'h0;
      offset_polarity_o   <= 1'b0;
      offset_magnitude_o  <= 6'h00;
    end
    else
    begin
      bias_current_trim_o <= bias_power_setting_r[7:4]; // R17
      offset_polarity_o   <= offset_adjustment_r[`BIT_POLARITY]; // R20
      offset_magnitude_o  <= offset_adjustment_r[5:0]; // R21
    end
  end

endmodule

// [sensor_cfg_consts.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the
//          sensor configuration register bank.
// Assumes: 8-bit register address and 8-bit data.
// Notes:   Definitions only.
`ifndef SENSOR_CFG_CONSTS_SVH
`define SENSOR_CFG_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_REV       8'h00
`define OFS_MAIN_CONFIGURATION_REG  8'h01
`define OFS_GAIN      8'h02
`define OFS_ITL       8'h03
`define OFS_IDL       8'h04
`define OFS_TIMEH     8'h05
`define OFS_BIAS      8'h06
`define OFS_OFFS      8'h08

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_BANK_EN   7
`define BIT_SERIAL    6
`define BIT_PWR_DOWN  5
`define BIT_AMP_PD    4
`define BIT_ROUTE     3
`define BIT_SOFT_RST  2
`define BIT_HIGH_Z    1
`define BIT_SNAPSHOT  0
`define BIT_DAC_EN    6
`define BIT_POLARITY  7

// ****************************************************************
// Reset values and write masks
// ****************************************************************
`define RST_MAIN_CONFIGURATION      8'h01
`define RST_GAIN      8'h00
`define RST_ITL       8'h0a
`define RST_IDL       8'h00
`define RST_TIMEH     8'h00
`define RST_BIAS      8'h00
`define RST_OFFS      8'h00
`define MSK_MAIN_CONFIGURATION      8'h7f
`define MSK_GAIN      8'h5f
`define MSK_TIMEH     8'h3f
`define MSK_BIAS      8'hf0
`define MSK_OFFS      8'hbf

// ****************************************************************
// Timing counts
// ****************************************************************
`define SOFT_RST_CYCLES 4'h4

`endif

// [sensor_cfg_pkg.sv]
// Purpose: Types shared by the sensor configuration register bank.
// Assumes: Nothing beyond an 8-bit register space.
// Notes:   Constants live in sensor_cfg_consts.svh.
package sensor_cfg_pkg;

  // Phases of the self-clearing soft reset.
  typedef enum logic [1:0] {
    soft_idle,
    soft_active,
    soft_done
  } soft_rst_state_t;

endpackage

// [sensor_cfg_sva.sv]
// Purpose: Port assertions for the sensor configuration register bank.
// Assumes: Synchronous active-high reset; bound by name to the bank ports.
// Notes:   Control outputs follow a taken write two cycles later.
module sensor_cfg_sva (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  wr_data_i,
  input wire logic        rd_valid_o,
  input wire logic        serial_port_select_o,
  input wire logic [5:0]  upper_data_oe_n_o,
  input wire logic        video_port_high_z_o,
  input wire logic        system_reset_o,
  input wire logic [4:0]  gain_code_o,
  input wire logic [10:0] integration_count_o,
  input wire logic [10:0] idle_count_o,
  input wire logic        offset_polarity_o,
  input wire logic [5:0]  offset_magnitude_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // Cycles left in which a running soft reset overrides host writes.
  logic [2:0] busy_cnt;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      busy_cnt <= 3'h0;
    else if (busy_cnt != 3'h0)
      busy_cnt <= busy_cnt - 3'h1;
    else if (wr_en_i && reg_addr_i == 8'h01 && wr_data_i[2])
      busy_cnt <= 3'h4;
  end
  // A write that the bank takes: none lands while the soft reset is active.
  wire wr_ok = wr_en_i && (busy_cnt == 3'h0);
  // ****************************************
  // Assertions
  // ****************************************
  read_pulse_a: assert property (rd_valid_o == $past(rd_en_i))
    else $error("read valid does not follow read request");
  serial_oe_a: assert property (serial_port_select_o |-> upper_data_oe_n_o == 6'h3f)
    else $error("upper data driven in serial mode");
  port_hiz_a: assert property (video_port_high_z_o |-> upper_data_oe_n_o == 6'h3f)
    else $error("video port driven while high impedance");
  soft_pulse_a: assert property (wr_ok && reg_addr_i == 8'h01 && wr_data_i[2]
    |-> ##2 system_reset_o [*4] ##1 !system_reset_o) else $error("soft reset pulse wrong");
  serial_wr_a: assert property (wr_ok && reg_addr_i == 8'h01 && !wr_data_i[2]
    |-> ##2 serial_port_select_o == $past(wr_data_i[6], 2)) else $error("port select wrong");
  gain_wr_a: assert property (wr_ok && reg_addr_i == 8'h02
    |-> ##2 gain_code_o == $past(wr_data_i[4:0], 2)) else $error("gain code wrong");
  integ_wr_a: assert property (wr_ok && reg_addr_i == 8'h03
    |-> ##2 integration_count_o[7:0] == $past(wr_data_i, 2)) else $error("integration low wrong");
  idle_wr_a: assert property (wr_ok && reg_addr_i == 8'h04
    |-> ##2 idle_count_o[7:0] == $past(wr_data_i, 2)) else $error("idle low wrong");
  high_wr_a: assert property (wr_ok && reg_addr_i == 8'h05 |-> ##2
    {idle_count_o[10:8], integration_count_o[10:8]} == $past(wr_data_i[5:0], 2))
    else $error("count high bits wrong");
  offs_wr_a: assert property (wr_ok && reg_addr_i == 8'h08 |-> ##2
    {offset_polarity_o, offset_magnitude_o} == {$past(wr_data_i[7], 2), $past(wr_data_i[5:0], 2)})
    else $error("offset fields wrong");
endmodule

// [cfg_host_model.sv]
// Purpose: Host side that hands decoded register bytes to the bank.
// Assumes: One request per task call, taken at the next rising edge.
// Notes:   Released address and data lines show the inverse of the last value.
module cfg_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rd_valid_o,
  input  wire logic [7:0] rd_data_o,
  output logic            wr_en_i,
  output logic            rd_en_i,
  output logic [7:0]      reg_addr_i,
  output logic [7:0]      wr_data_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Requests
  // ****************************************
  // Idle lines at time zero.
  initial
  begin
    wr_en_i    = 1'b0;
    rd_en_i    = 1'b0;
    reg_addr_i = 8'h00;
    wr_data_i  = 8'h00;
  end
  // One write: register address and data byte, presented together for one cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_en_i    <= 1'b1;
    reg_addr_i <= a;
    wr_data_i  <= d;
    @(posedge sys_clk_i);
    wr_en_i    <= 1'b0;
    reg_addr_i <= ~a;
    wr_data_i  <= ~d;
  endtask
  // One read: address phase, then the byte taken when valid shows.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    rd_en_i    <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    rd_en_i    <= 1'b0;
    reg_addr_i <= ~a;
    // Valid stands for one cycle, so the byte is taken at the edge that samples it high.
    @(posedge sys_clk_i);
    d = (rd_valid_o === 1'b1) ? rd_data_o : 8'hxx;
  endtask
endmodule

// [sensor_config_register_bank_bench.sv]
// Purpose: Self-checking bench for the sensor configuration register bank.
// Assumes: 100 ns clock, reset held for two cycles.
// Notes:   Each scenario drives through the host model and judges on return.
module sensor_config_register_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i, rst_i, wr_en_i, rd_en_i, rd_valid_o, serial_port_select_o;
  logic        video_port_high_z_o, sensor_power_down_o, amplifier_power_down_o;
  logic        amplifier_route_around_o, system_reset_o, snapshot_mode_o;
  logic        offset_bank_active_o, offset_polarity_o;
  logic [3:0]  bias_current_trim_o;
  logic [4:0]  gain_code_o;
  logic [5:0]  upper_data_oe_n_o, offset_magnitude_o;
  logic [7:0]  reg_addr_i, wr_data_i, rd_data_o, rdv;
  logic [10:0] integration_count_o, idle_count_o;
  int          error_cnt, n_checks;
  sensor_config_register_bank uut (.*);
  cfg_host_model host (.*);
  // ****************************************
  // Helpers
  // ****************************************
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rdv);
    chk(rdv, e);
  endtask
  // Lets a write reach the control outputs.
  task automatic settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] ev [9];
    ev = '{8'h01, 8'h01, 8'h00, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rchk(i[7:0], ev[i]);
    chk(snapshot_mode_o, 1'b1);
    chk(integration_count_o, 11'h00a);
  endtask
  task automatic t_main_configuration;
    logic [7:0] pat [4];
    pat = '{8'hfb, 8'h40, 8'h02, 8'h00};
    foreach (pat[i])
    begin
      host.wr(8'h01, pat[i]);
      settle;
      chk({serial_port_select_o, sensor_power_down_o, amplifier_power_down_o, amplifier_route_around_o, video_port_high_z_o, snapshot_mode_o}, {pat[i][6:3], pat[i][1:0]});
      chk(upper_data_oe_n_o, (pat[i][6] | pat[i][1]) ? 6'h3f : 6'h00);
      rchk(8'h01, pat[i] & 8'h7f);
    end
  endtask
  task automatic t_bank;
    host.wr(8'h06, 8'hf0);
    settle;
    rchk(8'h06, 8'h00);
    host.wr(8'h02, 8'h40);
    settle;
    chk(offset_bank_active_o, 1'b0);
    host.wr(8'h00, 8'h9e);
    host.wr(8'h02, 8'hff);
    host.wr(8'h06, 8'hef);
    settle;
    rchk(8'h00, 8'h81);
    rchk(8'h02, 8'h5f);
    rchk(8'h06, 8'he0);
    chk({offset_bank_active_o, gain_code_o, bias_current_trim_o}, {1'b1, 5'h1f, 4'he});
    host.wr(8'h08, 8'hc5);
    settle;
    rchk(8'h08, 8'h85);
    chk({offset_polarity_o, offset_magnitude_o}, {1'b1, 6'h05});
    host.wr(8'h08, 8'h3f);
    host.wr(8'h02, 8'h1f);
    settle;
    chk({offset_polarity_o, offset_magnitude_o}, {1'b0, 6'h3f});
    chk(offset_bank_active_o, 1'b0);
    host.wr(8'h00, 8'h00);
    host.wr(8'h06, 8'h00);
    settle;
    chk(bias_current_trim_o, 4'he);
    rchk(8'h06, 8'h00);
  endtask
  task automatic t_times;
    host.wr(8'h03, 8'h34);
    host.wr(8'h04, 8'h01);
    host.wr(8'h05, 8'hff);
    settle;
    rchk(8'h05, 8'h3f);
    chk(integration_count_o, 11'h734);
    chk(idle_count_o, 11'h701);
  endtask
  task automatic t_soft;
    int n;
    n = 0;
    host.wr(8'h01, 8'h45);
    repeat (10)
    begin
      @(posedge sys_clk_i);
      #1;
      n += system_reset_o;
    end
    chk(n[10:0], 11'h004);
    rchk(8'h01, 8'h41);
    rchk(8'h03, 8'h0a);
  endtask
  // Reset in mid-run brings the main configuration back to its defaults.
  task automatic t_rerun;
    host.wr(8'h01, 8'h7a);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    settle;
    chk({sensor_power_down_o, snapshot_mode_o}, 2'h1);
    chk(upper_data_oe_n_o, 6'h00);
    rchk(8'h01, 8'h01);
  endtask
  // Free-running clock.
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // Main sequence.
  initial
  begin
    rst_i = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_main_configuration;
    t_bank;
    t_times;
    t_soft;
    t_rerun;
    wrap_up;
  end
  // Cuts a hang short well past the expected run length.
  initial
  begin
    repeat (3000) @(posedge sys_clk_i);
    error_cnt++;
    wrap_up;
  end
endmodule
bind sensor_config_register_bank sensor_cfg_sva chk_i (.*);
